// ### include/ppd_params.svh
`ifndef PPD_PARAMS_SVH
`define PPD_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices on the plain register port
// ----------------------------------------------------------------------------
`define PPD_ADDR_W        3
`define PPD_IDX_PORT_A    3'h0
`define PPD_IDX_PORT_B    3'h1
`define PPD_IDX_PORT_C    3'h2
`define PPD_IDX_CTL_WORD  3'h3
`define PPD_IDX_IRQ_STAT  3'h4
`define PPD_IDX_IRQ_MASK  3'h5
`define PPD_IDX_DIR_CFG   3'h6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PPD_CTL_WORD_RST  8'h9B
`define PPD_DIR_CFG_RST   8'h00
`define PPD_IRQ_MASK_RST  2'h0
`define PPD_LATCH_RST     8'h00

// ----------------------------------------------------------------------------
// Control line roles and interrupt status bits
// ----------------------------------------------------------------------------
`define PPD_LINE_INTR_B   0
`define PPD_LINE_BUF_B    1
`define PPD_LINE_STB_B    2
`define PPD_LINE_INTR_A   3
`define PPD_LINE_STB_A    4
`define PPD_LINE_IBF_A    5
`define PPD_LINE_ACK_A    6
`define PPD_LINE_OBF_A    7
`define PPD_IRQ_W         2
`define PPD_IRQ_A         0
`define PPD_IRQ_B         1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PPD_DIR_RISE_NS   200
`define PPD_CLK_PERIOD_NS 100

`endif

// ### include/ppd_pkg.sv
// ----------------------------------------------------------------------------
// Shared types for the parallel port block
// ----------------------------------------------------------------------------
package ppd_pkg;

  // Operating mode of the port A group
  typedef enum logic [1:0] {MODE_BASIC, MODE_STROBED, MODE_BIDIR} mode_t;

  // Where a transceiver direction level comes from
  typedef enum logic [1:0] {DIR_STATIC_IN, DIR_STATIC_OUT, DIR_LINE4, DIR_LINE6} dir_src_t;

  // Control word as written by software (mode set form)
  typedef struct packed {
    logic       set_mode;
    logic [1:0] a_mode;
    logic       a_in;
    logic       cu_in;
    logic       b_mode;
    logic       b_in;
    logic       cl_in;
  } ctl_word_t;

  // Direction source configuration
  typedef struct packed {
    logic [3:0] unused;
    dir_src_t   b_src;
    dir_src_t   a_src;
  } dir_cfg_t;

endpackage

// ### rtl/dir_rise_delay.sv
`timescale 1ns/1ps
`include "ppd_params.svh"

// Passes a direction level, holding off each rising edge for CYCLES clocks
module dir_rise_delay #(
  parameter int CYCLES = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic lvl_i,
  output logic      lvl_o
);

  // --------------------------------------------------------------------------
  // Hold-off counter
  // --------------------------------------------------------------------------
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] DONE = W'(CYCLES);

  logic [W-1:0] cnt;  // Cycles the input has been high

  // Starts saturated so the input direction appears at once after reset
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt <= DONE;
    end else if (!lvl_i) begin
      cnt <= '0;
    end else if (cnt != DONE) begin
      cnt <= cnt + 1'b1;
    end
  end

  // Falls pass straight through; rises wait for the counter
  assign lvl_o = lvl_i & (cnt == DONE);

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  AST_RISE_HELD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(lvl_i) |-> !lvl_o[*2])
    else $error("direction rise passed too early");

endmodule // dir_rise_delay

// ### rtl/parallel_port_direction_handshake.sv
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`include "ppd_params.svh"

// ----------------------------------------------------------------------------
// Parallel port with transceiver direction control and handshake lines
// ----------------------------------------------------------------------------
module parallel_port_direction_handshake
  import ppd_pkg::*;
#(
  parameter int DIR_RISE_NS = `PPD_DIR_RISE_NS,
  parameter int CLK_NS      = `PPD_CLK_PERIOD_NS
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic [`PPD_ADDR_W-1:0] addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [7:0]             rdata_o,
  input  wire logic [7:0]             pa_i,
  output logic      [7:0]             pa_o,
  output logic      [7:0]             pa_oe_o,
  input  wire logic [7:0]             pb_i,
  output logic      [7:0]             pb_o,
  output logic      [7:0]             pb_oe_o,
  input  wire logic [7:0]             ctl_line_i,
  output logic      [7:0]             ctl_line_o,
  output logic      [7:0]             ctl_line_oe_o,
  output logic                        port_a_dir_ctl_o,
  output logic                        port_b_dir_ctl_o,
  output logic                        irq_o
);

  // --------------------------------------------------------------------------
  // Derived timing
  // --------------------------------------------------------------------------
  localparam int RISE_RAW    = (DIR_RISE_NS + CLK_NS - 1) / CLK_NS;  // Rounded up
  localparam int RISE_CYCLES = (RISE_RAW < 1) ? 1 : RISE_RAW;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Mode field of the control word to mode
  function automatic mode_t decode_mode(input logic [1:0] f);
    decode_mode = f[1] ? MODE_BIDIR : (f[0] ? MODE_STROBED : MODE_BASIC);
  endfunction

  // Direction level chosen by a source field; high means receive
  function automatic logic dir_level(input dir_src_t s, input logic [7:0] c);
    unique case (s)
      DIR_STATIC_IN:  dir_level = 1'b1;
      DIR_STATIC_OUT: dir_level = 1'b0;
      DIR_LINE4:      dir_level = c[`PPD_LINE_STB_A];
      DIR_LINE6:      dir_level = c[`PPD_LINE_ACK_A];
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Pin input synchronisers
  // --------------------------------------------------------------------------
  logic [23:0] pin_raw;      // All connector inputs
  logic [23:0] s1;           // First stage, read only by s2
  logic [23:0] s2;           // Second stage
  logic [23:0] s3;           // Third stage
  logic [23:0] pin_st;       // Accepted level
  logic [23:0] next_pin_st;  // Level accepted this edge

  assign pin_raw     = {ctl_line_i, pb_i, pa_i};
  // A bit changes only once stages two and three agree, which filters runts
  assign next_pin_st = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & pin_st);

  // Three-stage capture of the connector
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      pin_st <= '0;
    end else begin
      s1     <= pin_raw;
      s2     <= s1;
      s3     <= s2;
      pin_st <= next_pin_st;
    end
  end

  logic [7:0] pa_st;     // Port A pins
  logic [7:0] pb_st;     // Port B pins
  logic [7:0] ctl_st;    // Control line pins
  logic [7:0] ctl_fall;  // Falling edges of control lines

  assign pa_st    = pin_st[7:0];
  assign pb_st    = pin_st[15:8];
  assign ctl_st   = pin_st[23:16];
  assign ctl_fall = ctl_st & ~next_pin_st[23:16];

  // --------------------------------------------------------------------------
  // Register port decode
  // --------------------------------------------------------------------------
  logic wr_a, wr_b, wr_c, wr_cw, wr_mask, wr_dir;  // Write selects
  logic rd_a, rd_b, rd_stat;                       // Reads with side effects

  assign wr_a    = wr_i && (addr_i == `PPD_IDX_PORT_A);
  assign wr_b    = wr_i && (addr_i == `PPD_IDX_PORT_B);
  assign wr_c    = wr_i && (addr_i == `PPD_IDX_PORT_C);
  assign wr_cw   = wr_i && (addr_i == `PPD_IDX_CTL_WORD);
  assign wr_mask = wr_i && (addr_i == `PPD_IDX_IRQ_MASK);
  assign wr_dir  = wr_i && (addr_i == `PPD_IDX_DIR_CFG);
  assign rd_a    = rd_i && (addr_i == `PPD_IDX_PORT_A);
  assign rd_b    = rd_i && (addr_i == `PPD_IDX_PORT_B);
  assign rd_stat = rd_i && (addr_i == `PPD_IDX_IRQ_STAT);

  // --------------------------------------------------------------------------
  // Mode and control line latch
  // --------------------------------------------------------------------------
  ctl_word_t  cw;       // Last mode-set word
  mode_t      mode_a;   // Port A group mode
  logic [7:0] c_latch;  // Program-driven control line values
  logic       mode_set; // Mode-set write this cycle

  assign mode_set = wr_cw && wdata_i[7];

  // Mode set clears the line latch; otherwise single bit set/reset
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cw      <= ctl_word_t'(`PPD_CTL_WORD_RST);
      mode_a  <= MODE_BASIC;
      c_latch <= `PPD_LATCH_RST;
    end else if (mode_set) begin
      cw      <= ctl_word_t'(wdata_i);
      mode_a  <= decode_mode(wdata_i[6:5]);
      c_latch <= `PPD_LATCH_RST;
    end else if (wr_cw) begin
      c_latch[wdata_i[3:1]] <= wdata_i[0];
    end else if (wr_c) begin
      c_latch <= wdata_i;
    end
  end

  logic a_hs_in;   // Port A strobed input active
  logic a_hs_out;  // Port A handshaked output active
  logic b_hs;      // Port B strobed mode active

  assign a_hs_in  = (mode_a == MODE_BIDIR) || (mode_a == MODE_STROBED && cw.a_in);
  assign a_hs_out = (mode_a == MODE_BIDIR) || (mode_a == MODE_STROBED && !cw.a_in);
  assign b_hs     = cw.b_mode && (mode_a != MODE_BIDIR);

  // --------------------------------------------------------------------------
  // Handshake state
  // --------------------------------------------------------------------------
  logic [7:0] out_a, out_b;  // Output data latches
  logic [7:0] in_a, in_b;    // Strobed input latches
  logic       ibf_a, ibf_b;  // Input buffer full
  logic       obf_a_n;       // Output buffer full, low active
  logic       obf_b_n;
  logic       stb_a_f, ack_a_f, hs_b_f;  // Handshake strobes seen

  assign stb_a_f = ctl_fall[`PPD_LINE_STB_A];
  assign ack_a_f = ctl_fall[`PPD_LINE_ACK_A];
  assign hs_b_f  = ctl_fall[`PPD_LINE_STB_B];

  // Output latches load on writes
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      out_a <= `PPD_LATCH_RST;
      out_b <= `PPD_LATCH_RST;
    end else begin
      out_a <= wr_a ? wdata_i : out_a;
      out_b <= wr_b ? wdata_i : out_b;
    end
  end

  // Strobe sets buffer full and wins over a read in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || mode_set) begin
      ibf_a <= 1'b0;
      ibf_b <= 1'b0;
      in_a  <= `PPD_LATCH_RST;
      in_b  <= `PPD_LATCH_RST;
    end else begin
      ibf_a <= (a_hs_in && stb_a_f) || (ibf_a && !rd_a);
      ibf_b <= (b_hs && cw.b_in && hs_b_f) || (ibf_b && !rd_b);
      in_a  <= (a_hs_in && stb_a_f) ? pa_st : in_a;
      in_b  <= (b_hs && cw.b_in && hs_b_f) ? pb_st : in_b;
    end
  end

  // A write marks the buffer full; acknowledge empties it, write wins
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || mode_set) begin
      obf_a_n <= 1'b1;
      obf_b_n <= 1'b1;
    end else begin
      obf_a_n <= (wr_a && a_hs_out) ? 1'b0 : (ack_a_f ? 1'b1 : obf_a_n);
      obf_b_n <= (wr_b && b_hs && !cw.b_in) ? 1'b0 : (hs_b_f ? 1'b1 : obf_b_n);
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt requests per port
  // --------------------------------------------------------------------------
  logic intr_a_in, intr_a_out, intr_a, intr_b, intr_b_hs;

  assign intr_a_in  = ibf_a && c_latch[`PPD_LINE_STB_A] && ctl_st[`PPD_LINE_STB_A];
  assign intr_a_out = obf_a_n && c_latch[`PPD_LINE_ACK_A] && ctl_st[`PPD_LINE_ACK_A];
  assign intr_b_hs  = (cw.b_in ? ibf_b : obf_b_n) && c_latch[`PPD_LINE_STB_B]
                      && ctl_st[`PPD_LINE_STB_B];
  // Interrupt line 3 is program driven in basic mode, line 0 whenever port B is not strobed or port A is bidirectional
  assign intr_a = (mode_a == MODE_BASIC) ? c_latch[`PPD_LINE_INTR_A] :
                  ((a_hs_in && intr_a_in) || (a_hs_out && intr_a_out));
  assign intr_b = b_hs ? intr_b_hs : c_latch[`PPD_LINE_INTR_B];

  // --------------------------------------------------------------------------
  // Control line drivers
  // --------------------------------------------------------------------------
  logic line_b_drv;  // Lines 1 and 0 driven unless port B is unused

  assign line_b_drv = (mode_a != MODE_BIDIR);
  // Lines 6, 4 and 2 never drive: they stay buffered inputs
  assign ctl_line_oe_o = {1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
                          line_b_drv, line_b_drv};
  assign ctl_line_o = {
    a_hs_out ? obf_a_n : c_latch[`PPD_LINE_OBF_A],
    1'b0,
    a_hs_in ? ibf_a : c_latch[`PPD_LINE_IBF_A],
    1'b0,
    intr_a,
    1'b0,
    b_hs ? (cw.b_in ? ibf_b : obf_b_n) : c_latch[`PPD_LINE_BUF_B],
    intr_b
  };

  // --------------------------------------------------------------------------
  // Transceiver direction
  // --------------------------------------------------------------------------
  dir_cfg_t dcfg;       // Direction source selection
  logic     dir_a_lvl;  // Port A level before the hold-off
  logic     dir_a_dly;  // Port A level at the transceiver
  logic     dir_b_lvl;  // Port B level at the transceiver

  // Bidirectional mode ties port A to the acknowledge line
  assign dir_a_lvl = (mode_a == MODE_BIDIR) ? ctl_st[`PPD_LINE_ACK_A]
                                            : dir_level(dcfg.a_src, c_latch);
  assign dir_b_lvl = dir_level(dcfg.b_src, c_latch);

  dir_rise_delay #(
    .CYCLES (RISE_CYCLES)
  ) u_rise_a (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .lvl_i   (dir_a_lvl),
    .lvl_o   (dir_a_dly)
  );

  // Contention is software's to avoid; a high level never drives
  assign pa_oe_o          = {8{~dir_a_dly}};
  assign pb_oe_o          = {8{~dir_b_lvl & line_b_drv}};
  assign pa_o             = out_a;
  assign pb_o             = out_b;
  assign port_a_dir_ctl_o = dir_a_dly;
  assign port_b_dir_ctl_o = dir_b_lvl;

  // --------------------------------------------------------------------------
  // Interrupt status, mask and configuration
  // --------------------------------------------------------------------------
  logic [`PPD_IRQ_W-1:0] irq_stat, irq_mask, intr_prev, irq_ev;

  assign irq_ev = {intr_b, intr_a} & ~intr_prev;
  assign irq_o  = |(irq_stat & irq_mask);

  // Read clears the status, but an event in that cycle survives
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_stat  <= '0;
      irq_mask  <= `PPD_IRQ_MASK_RST;
      intr_prev <= '0;
      dcfg      <= dir_cfg_t'(`PPD_DIR_CFG_RST);
    end else begin
      irq_stat  <= (rd_stat ? '0 : irq_stat) | irq_ev;
      irq_mask  <= wr_mask ? wdata_i[`PPD_IRQ_W-1:0] : irq_mask;
      intr_prev <= {intr_b, intr_a};
      dcfg      <= wr_dir ? dir_cfg_t'(wdata_i) : dcfg;
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  logic [7:0] rd_pa, rd_pb, rd_pc, rd_mux;

  assign rd_pa = (mode_a == MODE_BASIC) ? (cw.a_in ? pa_st : out_a) : in_a;
  assign rd_pb = b_hs ? in_b : (cw.b_in ? pb_st : out_b);
  // Port C shows driven lines as driven and the rest from the pins
  assign rd_pc = (ctl_line_oe_o & ctl_line_o) | (~ctl_line_oe_o & ctl_st);
  assign rd_mux =
    (addr_i == `PPD_IDX_PORT_A)   ? rd_pa :
    (addr_i == `PPD_IDX_PORT_B)   ? rd_pb :
    (addr_i == `PPD_IDX_PORT_C)   ? rd_pc :
    (addr_i == `PPD_IDX_CTL_WORD) ? cw :
    (addr_i == `PPD_IDX_IRQ_STAT) ? {6'h00, irq_stat} :
    (addr_i == `PPD_IDX_IRQ_MASK) ? {6'h00, irq_mask} :
    (addr_i == `PPD_IDX_DIR_CFG)  ? dcfg : 8'h00;

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_B_RECEIVE_HIGH: assert property (
    dir_b_lvl |-> pb_oe_o == 8'h00)
    else $error("port B drives while level high");

  AST_B_DRIVE_LOW: assert property (
    (!dir_b_lvl && mode_a != MODE_BIDIR) |-> pb_oe_o == 8'hFF)
    else $error("port B not driving while level low");

  AST_A_FALL_FAST: assert property (
    $fell(dir_a_lvl) |-> pa_oe_o == 8'hFF)
    else $error("port A falling level was delayed");

  AST_PROG_LINE4: assert property (
    (dcfg.b_src == DIR_LINE4) |-> port_b_dir_ctl_o == c_latch[`PPD_LINE_STB_A])
    else $error("port B direction not following line 4");

  AST_LINES_INPUT: assert property (
    !ctl_line_oe_o[`PPD_LINE_STB_A] && !ctl_line_oe_o[`PPD_LINE_ACK_A])
    else $error("line 4 or 6 drives the connector");

  AST_MODE_SET: assert property (
    mode_set |=> mode_a == decode_mode($past(wdata_i[6:5])) && c_latch == 8'h00)
    else $error("mode set not applied");

  AST_BASIC_ROLES: assert property (
    (mode_a == MODE_BASIC) |-> ctl_line_oe_o == 8'hAB
      && ctl_line_o[`PPD_LINE_INTR_A] == c_latch[`PPD_LINE_INTR_A])
    else $error("basic mode line roles wrong");

  AST_STROBE_FILLS: assert property (
    (a_hs_in && stb_a_f) |=> ibf_a && ctl_line_o[`PPD_LINE_IBF_A] ##1 (ibf_a || $past(rd_a)))
    else $error("strobe did not fill port A buffer");

  AST_WRITE_OBF: assert property (
    (wr_a && a_hs_out) |=> !ctl_line_o[`PPD_LINE_OBF_A])
    else $error("write did not mark buffer full");

  AST_B_STROBE: assert property (
    (b_hs && cw.b_in && hs_b_f) |=> ctl_line_o[`PPD_LINE_BUF_B])
    else $error("port B strobe did not fill buffer");

  AST_BIDIR_ROLES: assert property (
    (mode_a == MODE_BIDIR) |-> ctl_line_oe_o == 8'hA8 && pb_oe_o == 8'h00)
    else $error("bidirectional line roles wrong");

  AST_BIDIR_ACK: assert property (
    (mode_a == MODE_BIDIR && !ctl_st[`PPD_LINE_ACK_A]) |-> pa_oe_o == 8'hFF)
    else $error("port A not driving during acknowledge");

  AST_RESET_INPUT: assert property (
    $rose(rst_b_i) |-> pa_oe_o == 8'h00 && pb_oe_o == 8'h00)
    else $error("transceiver drives after reset");

  COV_STROBED_IN: cover property (a_hs_in && stb_a_f ##[1:20] rd_a);
  COV_BIDIR_ACK: cover property (mode_a == MODE_BIDIR ##[1:20] ack_a_f);
  COV_IRQ: cover property ($rose(irq_o));

endmodule // parallel_port_direction_handshake

// ### tb/ppd_partner.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// User parallel equipment on the connector
// ----------------------------------------------------------------------------
module ppd_partner (
  input  wire logic [7:0] dev_a_i,    // Device port A value
  input  wire logic [7:0] dev_a_oe_i, // Device drives port A
  input  wire logic [7:0] dev_b_i,    // Device port B value
  input  wire logic [7:0] dev_b_oe_i, // Device drives port B
  input  wire logic [7:0] dev_c_i,    // Device control line values
  input  wire logic [7:0] dev_c_oe_i, // Device drives control lines
  input  wire logic [7:0] ext_a_i,    // Equipment port A value
  input  wire logic [7:0] ext_b_i,    // Equipment port B value
  input  wire logic [7:0] ext_c_i,    // Equipment control line value
  output logic      [7:0] pin_a_o,    // Resolved port A wires
  output logic      [7:0] pin_b_o,    // Resolved port B wires
  output logic      [7:0] pin_c_o     // Resolved control wires
);
  // Equipment drives only lines the device released, so no two drivers meet
  assign pin_a_o = (dev_a_oe_i & dev_a_i) | (~dev_a_oe_i & ext_a_i);
  assign pin_b_o = (dev_b_oe_i & dev_b_i) | (~dev_b_oe_i & ext_b_i);
  assign pin_c_o = (dev_c_oe_i & dev_c_i) | (~dev_c_oe_i & ext_c_i);
endmodule // ppd_partner

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "ppd_params.svh"

module tb_top;
  import ppd_pkg::*;
  logic       clk_i, rst_b_i, wr_i, rd_i, port_a_dir_ctl_o, port_b_dir_ctl_o, irq_o;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, pa_i, pa_o, pa_oe_o, pb_i, pb_o, pb_oe_o;
  logic [7:0] ctl_line_i, ctl_line_o, ctl_line_oe_o, ext_a, ext_b, ext_c, rv, v;
  int         fail_count, n_tests, cycles;

  parallel_port_direction_handshake #(.DIR_RISE_NS(200), .CLK_NS(100))
    parallel_port_direction_handshake_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pa_i(pa_i), .pa_o(pa_o), .pa_oe_o(pa_oe_o), .pb_i(pb_i), .pb_o(pb_o),
    .pb_oe_o(pb_oe_o), .ctl_line_i(ctl_line_i), .ctl_line_o(ctl_line_o),
    .ctl_line_oe_o(ctl_line_oe_o), .port_a_dir_ctl_o(port_a_dir_ctl_o),
    .port_b_dir_ctl_o(port_b_dir_ctl_o), .irq_o(irq_o));

  ppd_partner ppd_partner_inst (.dev_a_i(pa_o), .dev_a_oe_i(pa_oe_o), .dev_b_i(pb_o),
    .dev_b_oe_i(pb_oe_o), .dev_c_i(ctl_line_o), .dev_c_oe_i(ctl_line_oe_o),
    .ext_a_i(ext_a), .ext_b_i(ext_b), .ext_c_i(ext_c),
    .pin_a_o(pa_i), .pin_b_o(pb_i), .pin_c_o(ctl_line_i));

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Mode set word; upper and lower control groups left as inputs
  function automatic logic [7:0] mode_w(logic [1:0] am, logic ai, logic bm, logic bi);
    return {1'b1, am, ai, 1'b1, bm, bi, 1'b1};
  endfunction

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Clock at 10 MHz
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Hang guard; the sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    {rst_b_i, wr_i, rd_i, addr_i, wdata_i, ext_a, ext_b} = '0;
    ext_c = 8'hFF;
    v = 8'($urandom(37));
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    tick(1);
    chk("pa_oe rst", 8'h00, pa_oe_o);
    chk("pb_oe rst", 8'h00, pb_oe_o);
    chk("dir rst", 8'h03, {6'h00, port_a_dir_ctl_o, port_b_dir_ctl_o});
    chk("line_oe basic", 8'hAB, ctl_line_oe_o);
    rd(3'h3, rv);
    chk("ctl word", 8'h9B, rv);
    rd(3'h7, rv);
    chk("unmapped", 8'h00, rv);
    // Receive direction: connector data reach the ports
    for (int i = 0; i < 4; i++) begin
      ext_a <= 8'($urandom);
      ext_b <= 8'($urandom);
      tick(5);
      rd(3'h0, rv);
      chk("pa in", ext_a, rv);
      rd(3'h1, rv);
      chk("pb in", ext_b, rv);
    end
    // Static drive, basic output, line 3/0 from the latch
    wr(3'h6, 8'h05);
    chk("drive oe", 8'hFF, pa_oe_o & pb_oe_o);
    wr(3'h3, mode_w(2'b00, 1'b0, 1'b0, 1'b0));
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(3'h0, v);
      wr(3'h1, ~v);
      wr(3'h2, v);
      chk("pa out", v, pa_i);
      chk("pb out", ~v, pb_i);
      chk("line 3/0", v & 8'h09, ctl_line_o & 8'h09);
    end
    // Port A rise held two cycles, port B at once
    wr(3'h6, 8'h00);
    tick(1);
    chk("rise held", 8'h01, {6'h00, port_a_dir_ctl_o, port_b_dir_ctl_o});
    tick(2);
    chk("rise done", 8'h00, {pa_oe_o[0], port_a_dir_ctl_o, pb_oe_o[5:0]} ^ 8'h40);
    // Program control through latch bits 4 and 6
    wr(3'h6, 8'h0E);
    wr(3'h3, 8'h08);
    wr(3'h3, 8'h0C);
    chk("prog drive", 8'hFF, pa_oe_o & pb_oe_o);
    wr(3'h3, 8'h0D);
    chk("prog recv", 8'h00, pb_oe_o);
    chk("line 4/6 in", 8'h00, ctl_line_oe_o & 8'h50);
    // Strobed input on both ports, mask off then on
    wr(3'h6, 8'h00);
    for (int m = 0; m < 2; m++) begin
      wr(3'h3, mode_w(2'b01, 1'b1, 1'b1, 1'b1));
      wr(3'h3, 8'h09);
      wr(3'h3, 8'h05);
      wr(3'h5, m ? 8'h03 : 8'h00);
      v = 8'($urandom);
      ext_a <= v;
      ext_b <= ~v;
      tick(5);
      ext_c <= 8'hEB;
      tick(5);
      chk("buf full", 8'h22, ctl_line_o & 8'h22);
      ext_c <= 8'hFF;
      ext_a <= ~v;
      tick(5);
      chk("intr lines", 8'h09, ctl_line_o & 8'h09);
      chk("irq", {7'h00, m == 1}, {7'h00, irq_o});
      rd(3'h0, rv);
      chk("pa latched", v, rv);
      rd(3'h1, rv);
      chk("pb latched", ~v, rv);
      tick(1);
      chk("buf empty", 8'h00, ctl_line_o & 8'h22);
      rd(3'h4, rv);
      chk("status", 8'h03, rv & 8'h03);
      rd(3'h4, rv);
      chk("status clr", 8'h00, rv & 8'h03);
      chk("irq clr", 8'h00, {7'h00, irq_o});
    end
    // Bidirectional port A follows acknowledge on line 6
    wr(3'h6, 8'h04);
    wr(3'h3, mode_w(2'b10, 1'b1, 1'b0, 1'b1));
    v = 8'($urandom);
    wr(3'h0, v);
    chk("obf low", 8'h00, ctl_line_o & 8'h80);
    ext_c <= 8'hBF;
    tick(5);
    chk("bidir drive", 8'hFF, pa_oe_o);
    chk("bidir data", v, pa_i);
    chk("obf cleared", 8'h80, ctl_line_o & 8'h80);
    chk("bidir pb", 8'h00, pb_oe_o);
    chk("bidir lines", 8'h00, ctl_line_oe_o & 8'h57);
    ext_c <= 8'hFF;
    tick(7);
    chk("bidir recv", 8'h00, pa_oe_o);
    give_verdict();
  end
endmodule // tb_top
